// ==== tb/dpmgc_slave_model.sv ====
`default_nettype none
module dpmgc_slave_model
(
   input  wire logic       clk,       // module clock
   output logic            started,   // exchange started flag
   output logic            diag_evt,  // diagnostic strobe
   output logic      [6:0] diag_stn,  // its station
   output logic            cyc_end,   // bus cycle end strobe
   output logic            own_valid, // address parameter present
   output logic      [6:0] own_addr   // configured address
);
   timeunit 1ns;
   timeprecision 1ps;
   // quiet link after power-up
   initial
   begin
      started = 1'b0;
      diag_evt = 1'b0;
      diag_stn = 7'h00;
      cyc_end = 1'b0;
      own_valid = 1'b0;
      own_addr = 7'h00;
   end
   // one diagnostic; the station line is scrambled after so a stale value is never trusted
   task automatic diag(input logic [6:0] s);
      @(posedge clk);
      diag_evt <= 1'b1;
      diag_stn <= s;
      @(posedge clk);
      diag_evt <= 1'b0;
      diag_stn <= ~s;
   endtask : diag
   // cycle end strobe n clocks after the call
   task automatic cycle(input int n);
      repeat (n - 1) @(posedge clk);
      cyc_end <= 1'b1;
      @(posedge clk);
      cyc_end <= 1'b0;
   endtask : cycle
   task automatic set_start(input logic v);
      @(posedge clk);
      started <= v;
   endtask : set_start
   task automatic set_own(input logic v, input logic [6:0] a);
      @(posedge clk);
      own_valid <= v;
      own_addr <= a;
   endtask : set_own
endmodule : dpmgc_slave_model
`default_nettype wire

// ==== tb/testbench.sv ====
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import dpmgc_pkg::*;
   logic        ref_clk = 1'b0;
   logic        ce = 1'b1;
   logic [2:0]  hsize = 3'h2;
   logic        rst_n = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd_q;
   logic        hreadyout, hresp, started, devt, cend, ovalid, req, gc_req;
   logic        unfrz, frz, unsync, sync, gc_all, diag_det, lamp, store;
   logic [6:0]  dstn, oaddr, store_stn;
   logic [7:0]  groups;
   logic [15:0] v;
   logic [7:0]  oa [4] = '{8'h80, 8'hFD, 8'hFE, 8'h05};
   int          gaps [3] = '{5, 2, 4};
   int          mismatches = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          stores = 0;
   int          exp_min;
   integer      seed = 32'h843ad77f;

   always #2 ref_clk = ~ref_clk;

   dpmgc_top #(.SEC_CYC(20), .MS_CYC(8)) dut
   (
      .REF_CLK(ref_clk), .RST_N(rst_n), .CE(ce), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
      .EXCH_STARTED(started), .DIAG_EVT(devt), .DIAG_STN(dstn),
      .OWN_ADDR_VALID(ovalid), .OWN_ADDR(oaddr), .CYCLE_END(cend),
      .EXCH_START_REQ(req), .GC_REQ(gc_req), .GC_UNFREEZE(unfrz), .GC_FREEZE(frz),
      .GC_UNSYNC(unsync), .GC_SYNC(sync), .GC_GROUPS(groups), .GC_ALL(gc_all),
      .DIAG_DETECTED(diag_det), .BUS_FAULT_LAMP(lamp), .DIAG_STORE(store),
      .DIAG_STORE_STN(store_stn)
   );

   dpmgc_slave_model slv
   (
      .clk(ref_clk), .started(started), .diag_evt(devt), .diag_stn(dstn),
      .cyc_end(cend), .own_valid(ovalid), .own_addr(oaddr)
   );

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one single word transfer; the master waits for the slave, however long it takes
   task automatic bus(input logic w, input logic [11:0] i, input logic [15:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      haddr <= {18'h0, i, 2'h0};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {16'h0, d};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd_q = hrdata;
   endtask : bus

   task automatic rdc(input logic [11:0] i, input logic [31:0] exp);
      bus(1'b0, i, 16'h0);
      chk(rd_q, exp);
   endtask : rdc

   // cycle ceiling, stores seen and hang guard
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (store === 1'b1)
         stores <= stores + 1;
      if (cycles == 20000)
      begin
         mismatches++;
         test_done();
      end
   end

   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      // values after reset, read-only and unmapped places
      rdc(IDX_CMD, 32'h0);
      rdc(IDX_SET, 32'h0);
      rdc(IDX_MIN, 32'hFFFF);
      rdc(IDX_CUR, 32'h0);
      bus(1'b1, IDX_REM, 16'h5);
      rdc(IDX_REM, 32'h0);
      bus(1'b1, 12'h400, 16'h1234);
      rdc(12'h400, 32'h0);
      // both conflicts first, then unused bits with all groups, then random command words
      for (int k = 0; k < 12; k++)
      begin
         v = (k == 0) ? 16'h003C : (k == 1) ? 16'hFF03 : 16'($random(seed));
         bus(1'b1, IDX_CMD, v);
         #1;
         chk(32'({gc_req, unfrz, frz, unsync, sync, gc_all, groups}), 32'({1'b1, v[2], v[3] & ~v[2], v[4], v[5] & ~v[4], v[15:8] == 8'h0, v[15:8]}));
         rdc(IDX_CMD, 32'(v & 16'hFF3C));
      end
      // own address, bit 7 of the table is the valid flag
      for (int k = 0; k < 4; k++)
      begin
         slv.set_own(oa[k][7], oa[k][6:0]);
         repeat (2) @(posedge ref_clk);
         rdc(IDX_OWN, (oa[k][7] && oa[k][6:0] <= 7'd125) ? 32'(oa[k][6:0]) : 32'hFFFF);
      end
      // cycle gaps kept half a unit off the ms boundary
      slv.cycle(20);
      exp_min = 'hFFFF;
      for (int k = 0; k < 3; k++)
      begin
         slv.cycle(8 * gaps[k] + 4);
         if (gaps[k] < exp_min)
            exp_min = gaps[k];
      end
      rdc(IDX_CUR, 32'(gaps[2]));
      rdc(IDX_MIN, 32'(exp_min));
      // suppression window of three steps
      bus(1'b1, IDX_SET, 16'd3);
      bus(1'b1, IDX_CTRL, 16'h1);
      #1;
      chk(32'({req, hresp}), 32'h2);
      slv.set_start(1'b1);
      repeat (4) @(posedge ref_clk);
      rdc(IDX_REM, 32'd3);
      slv.diag(7'h11);
      bus(1'b1, IDX_SET, 16'd7);
      rdc(IDX_SET, 32'd3);
      chk(32'({diag_det, lamp, 16'(stores)}), 32'h0);
      repeat (10) @(posedge ref_clk);
      rdc(IDX_REM, 32'd2);
      bus(1'b1, IDX_CTRL, 16'h0);
      repeat (60) @(posedge ref_clk);
      rdc(IDX_REM, 32'd2);
      bus(1'b1, IDX_CTRL, 16'h1);
      repeat (60) @(posedge ref_clk);
      rdc(IDX_REM, 32'd0);
      // after the window a diagnostic is reported, then cleared by write-one
      slv.diag(7'h2A);
      @(posedge ref_clk);
      #1;
      chk(32'({diag_det, lamp, store_stn}), 32'h1AA);
      chk(32'(stores), 32'd1);
      bus(1'b1, IDX_STAT, 16'h2);
      rdc(IDX_STAT, 32'h1);
      // clock enable low: a diagnostic arriving then must leave no trace
      @(posedge ref_clk);
      ce <= 1'b0;
      slv.diag(7'h33);
      @(posedge ref_clk);
      ce <= 1'b1;
      #1;
      chk(32'({diag_det, lamp, 16'(stores)}), 32'h1);
      test_done();
   end
endmodule : testbench
`default_nettype wire

// ==== verilog/dpmgc_pkg.sv ====
`default_nettype none
package dpmgc_pkg;
   // register indices, the byte address on the bus is four times the index
   localparam logic [11:0] IDX_STAT = 12'h000;
   localparam logic [11:0] IDX_CTRL = 12'h001;
   localparam logic [11:0] IDX_CMD  = 12'h821;
   localparam logic [11:0] IDX_SET  = 12'h824;
   localparam logic [11:0] IDX_REM  = 12'h825;
   localparam logic [11:0] IDX_OWN  = 12'h8D1;
   localparam logic [11:0] IDX_CUR  = 12'h8E0;
   localparam logic [11:0] IDX_MIN  = 12'h8E1;
   // command word fields
   localparam int CMD_UNFRZ   = 2;
   localparam int CMD_FRZ     = 3;
   localparam int CMD_UNSYNC  = 4;
   localparam int CMD_SYNC    = 5;
   localparam int CMD_GRP_LSB = 8;
   localparam logic [15:0] CMD_WMASK = 16'hFF3C;
   // status and control bit positions
   localparam int ST_STARTED = 0;
   localparam int ST_DIAG    = 1;
   localparam int ST_WIN     = 2;
   localparam int CTRL_REQ   = 0;
   // values after reset, and the highest own address
   localparam logic [15:0] CMD_RST  = 16'h0000;
   localparam logic [15:0] SET_RST  = 16'h0000;
   localparam logic [15:0] REM_RST  = 16'h0000;
   localparam logic [15:0] CUR_RST  = 16'h0000;
   localparam logic [15:0] MIN_RST  = 16'hFFFF;
   localparam logic [15:0] OWN_NONE = 16'hFFFF;
   localparam logic [6:0]  OWN_MAX  = 7'h7D;
   // timing: one suppression step is 1 s, one cycle-time unit is 1 ms
   localparam int CLK_HZ      = 250_000_000;
   localparam int SUP_STEP_S  = 1;
   localparam int CYC_UNIT_MS = 1;
   localparam int SEC_CYCLES  = SUP_STEP_S * CLK_HZ;
   localparam int MS_CYCLES   = CYC_UNIT_MS * (CLK_HZ / 1000);

   typedef enum logic [3:0] {
      R_NONE, R_STAT, R_CTRL, R_CMD, R_SET, R_REM, R_OWN, R_CUR, R_MIN
   } dpmgc_reg_t;

   // word address decode, anything outside the map is R_NONE
   function automatic dpmgc_reg_t dpmgc_decode(input logic [31:0] a);
      dpmgc_reg_t r;
      r = R_NONE;
      if (a[31:14] != 18'h00000 || a[1:0] != 2'h0) r = R_NONE;
      else if (a[13:2] == IDX_STAT) r = R_STAT;
      else if (a[13:2] == IDX_CTRL) r = R_CTRL;
      else if (a[13:2] == IDX_CMD)  r = R_CMD;
      else if (a[13:2] == IDX_SET)  r = R_SET;
      else if (a[13:2] == IDX_REM)  r = R_REM;
      else if (a[13:2] == IDX_OWN)  r = R_OWN;
      else if (a[13:2] == IDX_CUR)  r = R_CUR;
      else if (a[13:2] == IDX_MIN)  r = R_MIN;
      return r;
   endfunction : dpmgc_decode
endpackage : dpmgc_pkg
`default_nettype wire

// ==== verilog/dpmgc_sup_if.sv ====
`default_nettype none
interface dpmgc_sup_if;
   logic        ce;        // clock enable
   logic        load;      // reload from setting
   logic        run;       // countdown allowed
   logic [15:0] setting;   // configured seconds
   logic [15:0] remaining; // seconds left
   logic        active;    // window still open
   modport timer (input ce, load, run, setting, output remaining, active);
   modport ctrl  (output ce, load, run, setting, input remaining, active);
endinterface : dpmgc_sup_if
`default_nettype wire

// ==== verilog/dpmgc_sup_timer.sv ====
`default_nettype none
module dpmgc_sup_timer
   import dpmgc_pkg::*;
#(
   parameter int SEC_CYC = dpmgc_pkg::SEC_CYCLES // clocks per second
)(
   input wire logic      clk,   // module clock
   input wire logic      rst_n, // synchronised reset, active low
   dpmgc_sup_if.timer    sup    // control side
);
   logic [31:0] pre_q;
   logic [15:0] rem_q;
   logic        tick;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   assign tick = (pre_q == 32'(SEC_CYC - 1));

   // one-second prescaler, restarts on reload so the first step is a full second
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         pre_q <= 32'h00000000;
      else if (sup.ce)
      begin
         if (sup.load || tick)
            pre_q <= 32'h00000000;
         else if (sup.run && rem_q != 16'h0000)
            pre_q <= pre_q + 32'h00000001;
      end

   // remaining seconds: load, step down, stick at zero, freeze when stopped
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         rem_q <= REM_RST;
      else if (sup.ce)
      begin
         if (sup.load)
            rem_q <= sup.setting; // see RL17
         else if (sup.run && tick && rem_q != 16'h0000)
            rem_q <= rem_q - 16'h0001; // see RL11 see RL12 see RL13
      end

   assign sup.remaining = rem_q;
   assign sup.active    = (rem_q != 16'h0000);

   AST_SUP_LOAD: assert property (sup.ce && sup.load |=> rem_q == $past(sup.setting)) // see RL17
      else $error("remaining not loaded from setting");
   AST_SUP_ZERO: assert property (rem_q == 16'h0000 && !sup.load |=> rem_q == 16'h0000) // see RL12
      else $error("remaining left zero without reload");
   AST_SUP_FROZEN: assert property (!sup.run && !sup.load |=> $stable(rem_q)) // see RL13
      else $error("remaining moved while stopped");
   AST_SUP_STEP: assert property (sup.ce && !sup.load && rem_q != 16'h0000 |=> // see RL11
      rem_q == $past(rem_q) || rem_q == $past(rem_q) - 16'h0001)
      else $error("remaining changed by more than one step");
   CV_SUP_EXPIRE: cover property (sup.active ##1 !sup.active);
endmodule : dpmgc_sup_timer
`default_nettype wire

// ==== verilog/dpmgc_top.sv ====
// Contract
// RL1: host codes services b2-b5, groups b8-b15
// RL2: b2 unfreeze, b3 freeze, b4 unsync, b5 sync
// RL3: b8..b15 select groups one to eight
// RL4: no group bit set means all stations
// RL5: sync with unsync executes only unsync
// RL6: freeze with unfreeze executes only unfreeze
// RL7: bits 0,1,6,7 read zero; reset zero
// RL8: suppression setting, 0 to 65535 seconds
// RL9: window blocks flag, lamp, store, station bit
// RL10: setting writes ignored while request high
// RL11: remaining counts down by one per second
// RL12: remaining holds zero after time elapsed
// RL13: remaining frozen while request is low
// RL14: own address 0..7D, or FFFF unconfigured
// RL15: current cycle time in milliseconds
// RL16: minimum cycle time in milliseconds
// RL17: started rise after request loads remaining
//
// Implementation choice: the AHB-Lite interface to the registers.
`default_nettype none
module dpmgc_top
   import dpmgc_pkg::*;
#(
   parameter int SEC_CYC = dpmgc_pkg::SEC_CYCLES, // clocks per suppression second
   parameter int MS_CYC  = dpmgc_pkg::MS_CYCLES   // clocks per millisecond
)(
   input  wire logic        REF_CLK,         // 250 MHz clock
   input  wire logic        RST_N,           // async reset, active low
   input  wire logic        CE,              // clock enable, low freezes state
   input  wire logic        HSEL,            // ahb select
   input  wire logic [31:0] HADDR,           // ahb address
   input  wire logic [1:0]  HTRANS,          // ahb transfer type
   input  wire logic        HWRITE,          // ahb write
   input  wire logic [2:0]  HSIZE,           // ahb size, words only
   input  wire logic [31:0] HWDATA,          // ahb write data
   input  wire logic        HREADY,          // ahb bus ready
   output logic      [31:0] HRDATA,          // ahb read data
   output logic             HREADYOUT,       // ahb slave ready
   output logic             HRESP,           // ahb response, always okay
   input  wire logic        EXCH_STARTED,    // exchange started flag from link
   input  wire logic        DIAG_EVT,        // slave diagnostic arrived
   input  wire logic [6:0]  DIAG_STN,        // station of that diagnostic
   input  wire logic        OWN_ADDR_VALID,  // address parameter present
   input  wire logic [6:0]  OWN_ADDR,        // configured station address
   input  wire logic        CYCLE_END,       // bus cycle finished
   output logic             EXCH_START_REQ,  // exchange start request to link
   output logic             GC_REQ,          // global control issue pulse
   output logic             GC_UNFREEZE,     // service unfreeze
   output logic             GC_FREEZE,       // service freeze
   output logic             GC_UNSYNC,       // service unsync
   output logic             GC_SYNC,         // service sync
   output logic      [7:0]  GC_GROUPS,       // group 1..8 select
   output logic             GC_ALL,          // broadcast to every station
   output logic             DIAG_DETECTED,   // diagnostic detected flag
   output logic             BUS_FAULT_LAMP,  // bus fault lamp
   output logic             DIAG_STORE,      // store error data pulse
   output logic      [6:0]  DIAG_STORE_STN   // station to store and mark
);
   import dpmgc_pkg::*;

   logic        rst_s1_q;
   logic        rst_n;
   dpmgc_reg_t  sel_q;
   logic        wr_pend_q;
   logic        rd_pend_q;
   logic        hready_q;
   logic [31:0] hrdata_q;
   logic [31:0] rd_d;
   logic [15:0] cmd_q;
   logic [15:0] wcmd;
   logic [15:0] set_q;
   logic        req_q;
   logic        started_q;
   logic        armed_q;
   logic        diag_q;
   logic        store_q;
   logic [6:0]  store_stn_q;
   logic        lamp_q;
   logic [15:0] own_q;
   logic [31:0] ms_pre_q;
   logic [15:0] ms_cnt_q;
   logic [15:0] cur_q;
   logic [15:0] min_q;
   logic        gc_req_q;
   logic [3:0]  gc_svc_q;
   logic [7:0]  gc_grp_q;
   logic        gc_all_q;
   logic        wr_cmd;
   logic        wr_set;
   logic        wr_ctrl;
   logic        wr_stat;
   logic        addr_ok;
   logic        ms_tick;
   logic        suppress;
   logic        diag_pass;
   logic [15:0] ms_now;

   dpmgc_sup_if sup ();

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!rst_n);

   // reset released through two flops; assertion stays asynchronous
   always_ff @(posedge REF_CLK or negedge RST_N)
      if (!RST_N)
      begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end

   // ahb address phase: writes take no wait, reads add one so data is current
   assign addr_ok = HSEL && HTRANS[1] && HREADY;
   always_ff @(posedge REF_CLK or negedge rst_n)
      if (!rst_n)
      begin
         sel_q     <= R_NONE;
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         hready_q  <= 1'b1;
      end
      else if (CE)
      begin
         wr_pend_q <= addr_ok && HWRITE;
         rd_pend_q <= addr_ok && !HWRITE;
         hready_q  <= !(addr_ok && !HWRITE);
         if (addr_ok)
            sel_q <= dpmgc_decode(HADDR);
      end

   // read mux, unmapped words read as zero
   always_comb
   begin
      rd_d = 32'h00000000;
      case (sel_q)
         R_STAT: rd_d = {29'h0, sup.active, diag_q, started_q};
         R_CTRL: rd_d = {31'h0, req_q};
         R_CMD:  rd_d = {16'h0, cmd_q};
         R_SET:  rd_d = {16'h0, set_q};
         R_REM:  rd_d = {16'h0, sup.remaining};
         R_OWN:  rd_d = {16'h0, own_q};
         R_CUR:  rd_d = {16'h0, cur_q};
         R_MIN:  rd_d = {16'h0, min_q};
         default: rd_d = 32'h00000000;
      endcase
   end

   // read data captured in the wait cycle and held until the next read
   always_ff @(posedge REF_CLK or negedge rst_n)
      if (!rst_n)
         hrdata_q <= 32'h00000000;
      else if (CE && rd_pend_q)
         hrdata_q <= rd_d;

   assign HRDATA    = hrdata_q;
   assign HREADYOUT = hready_q;
   assign HRESP     = 1'b0 & hready_q;

   // write strobes in the data phase
   assign wr_cmd  = CE && wr_pend_q && sel_q == R_CMD;
   assign wr_set  = CE && wr_pend_q && sel_q == R_SET && !req_q; // see RL10
   assign wr_ctrl = CE && wr_pend_q && sel_q == R_CTRL;
   assign wr_stat = CE && wr_pend_q && sel_q == R_STAT;
   assign wcmd    = HWDATA[15:0] & CMD_WMASK; // see RL7

   // command word, unused bits never stored
   always_ff @(posedge REF_CLK or negedge rst_n)
      if (!rst_n)
         cmd_q <= CMD_RST; // see RL7
      else if (wr_cmd)
         cmd_q <= wcmd;

   // each command write issues one request pulse; the losing half of a pair is dropped
   always_ff @(posedge REF_CLK or negedge rst_n)
      if (!rst_n)
      begin
         gc_req_q <= 1'b0;
         gc_svc_q <= 4'h0;
         gc_grp_q <= 8'h00;
         gc_all_q <= 1'b0;
      end
      else if (CE)
      begin
         gc_req_q <= wr_cmd;
         if (wr_cmd)
         begin
            gc_svc_q[0] <= wcmd[CMD_UNFRZ]; // see RL2
            gc_svc_q[1] <= wcmd[CMD_FRZ] && !wcmd[CMD_UNFRZ]; // see RL6
            gc_svc_q[2] <= wcmd[CMD_UNSYNC]; // see RL2
            gc_svc_q[3] <= wcmd[CMD_SYNC] && !wcmd[CMD_UNSYNC]; // see RL5
            gc_grp_q    <= wcmd[CMD_GRP_LSB +: 8]; // see RL3
            gc_all_q    <= (wcmd[CMD_GRP_LSB +: 8] == 8'h00); // see RL4
         end
      end

   assign GC_REQ      = gc_req_q;
   assign GC_UNFREEZE = gc_svc_q[0];
   assign GC_FREEZE   = gc_svc_q[1];
   assign GC_UNSYNC   = gc_svc_q[2];
   assign GC_SYNC     = gc_svc_q[3];
   assign GC_GROUPS   = gc_grp_q;
   assign GC_ALL      = gc_all_q;

   // suppression setting, whole 16-bit range of seconds
   always_ff @(posedge REF_CLK or negedge rst_n)
      if (!rst_n)
         set_q <= SET_RST;
      else if (wr_set)
         set_q <= HWDATA[15:0]; // see RL8

   // exchange start request from software, started flag sampled from the link
   always_ff @(posedge REF_CLK or negedge rst_n)
      if (!rst_n)
      begin
         req_q     <= 1'b0;
         started_q <= 1'b0;
      end
      else if (CE)
      begin
         started_q <= EXCH_STARTED;
         if (wr_ctrl)
            req_q <= HWDATA[CTRL_REQ];
      end

   assign EXCH_START_REQ = req_q;

   // armed by a fresh request so only the first started edge reloads the window
   always_ff @(posedge REF_CLK or negedge rst_n)
      if (!rst_n)
         armed_q <= 1'b0;
      else if (CE)
      begin
         if (wr_ctrl && HWDATA[CTRL_REQ] && !req_q)
            armed_q <= 1'b1;
         else if (sup.load || !req_q)
            armed_q <= 1'b0;
      end

   assign sup.ce      = CE;
   assign sup.load    = armed_q && req_q && EXCH_STARTED && !started_q; // see RL17
   assign sup.run     = req_q && started_q; // see RL13
   assign sup.setting = set_q;

   dpmgc_sup_timer #(
      .SEC_CYC (SEC_CYC)
   ) u_sup (
      .clk   (REF_CLK),
      .rst_n (rst_n),
      .sup   (sup.timer)
   );

   // diagnostics are dropped while the window is open or about to open
   assign suppress  = sup.active || sup.load; // see RL9 see RL11
   assign diag_pass = CE && DIAG_EVT && !suppress;

   // detected flag is sticky, write one clears, a new event wins over the clear
   always_ff @(posedge REF_CLK or negedge rst_n)
      if (!rst_n)
         diag_q <= 1'b0;
      else if (diag_pass)
         diag_q <= 1'b1; // see RL9
      else if (wr_stat && HWDATA[ST_DIAG])
         diag_q <= 1'b0;

   // store strobe and station mark only for diagnostics that got through
   always_ff @(posedge REF_CLK or negedge rst_n)
      if (!rst_n)
      begin
         store_q     <= 1'b0;
         store_stn_q <= 7'h00;
         lamp_q      <= 1'b0;
      end
      else if (CE)
      begin
         store_q <= diag_pass; // see RL9
         if (diag_pass)
            store_stn_q <= DIAG_STN;
         lamp_q <= diag_pass || (diag_q && !(wr_stat && HWDATA[ST_DIAG]));
      end

   assign DIAG_DETECTED  = diag_q;
   assign BUS_FAULT_LAMP = lamp_q;
   assign DIAG_STORE     = store_q;
   assign DIAG_STORE_STN = store_stn_q;

   // own address, out-of-range values count as not configured
   always_ff @(posedge REF_CLK or negedge rst_n)
      if (!rst_n)
         own_q <= OWN_NONE;
      else if (CE)
      begin
         if (OWN_ADDR_VALID && OWN_ADDR <= OWN_MAX)
            own_q <= {9'h000, OWN_ADDR}; // see RL14
         else
            own_q <= OWN_NONE; // see RL14
      end

   // millisecond prescaler for the cycle-time measurement
   assign ms_tick = (ms_pre_q == 32'(MS_CYC - 1));
   always_ff @(posedge REF_CLK or negedge rst_n)
      if (!rst_n)
         ms_pre_q <= 32'h00000000;
      else if (CE)
      begin
         if (CYCLE_END || ms_tick)
            ms_pre_q <= 32'h00000000;
         else
            ms_pre_q <= ms_pre_q + 32'h00000001;
      end

   // elapsed whole milliseconds in the running cycle, saturating
   assign ms_now = (ms_tick && ms_cnt_q != 16'hFFFF) ? ms_cnt_q + 16'h0001 : ms_cnt_q;
   always_ff @(posedge REF_CLK or negedge rst_n)
      if (!rst_n)
         ms_cnt_q <= 16'h0000;
      else if (CE)
      begin
         if (CYCLE_END)
            ms_cnt_q <= 16'h0000;
         else
            ms_cnt_q <= ms_now;
      end

   // latest and shortest cycle; minimum starts at all ones meaning none seen
   always_ff @(posedge REF_CLK or negedge rst_n)
      if (!rst_n)
      begin
         cur_q <= CUR_RST;
         min_q <= MIN_RST;
      end
      else if (CE && CYCLE_END)
      begin
         cur_q <= ms_now; // see RL15
         if (ms_now < min_q)
            min_q <= ms_now; // see RL16
      end

   AST_CMD_FIXED: assert property (cmd_q[1:0] == 2'h0 && cmd_q[7:6] == 2'h0) // see RL7
      else $error("unused command bits not zero");
   AST_GC_ISSUE: assert property (wr_cmd |=> GC_REQ && GC_GROUPS == cmd_q[15:8]) // see RL3
      else $error("command write did not issue service to selected groups");
   AST_GC_MAP: assert property (GC_REQ |-> GC_UNFREEZE == cmd_q[CMD_UNFRZ] && GC_UNSYNC == cmd_q[CMD_UNSYNC]) // see RL2
      else $error("service bits do not follow command word");
   AST_UNSYNC_WINS: assert property (GC_REQ && cmd_q[CMD_UNSYNC] |-> !GC_SYNC) // see RL5
      else $error("sync issued together with unsync");
   AST_UNFRZ_WINS: assert property (GC_REQ && cmd_q[CMD_UNFRZ] |-> !GC_FREEZE) // see RL6
      else $error("freeze issued together with unfreeze");
   AST_GC_ALL: assert property (GC_REQ |-> GC_ALL == (cmd_q[15:8] == 8'h00)) // see RL4
      else $error("broadcast flag wrong for group bits");
   AST_SET_IGNORED: assert property (CE && wr_pend_q && sel_q == R_SET && req_q |=> $stable(set_q)) // see RL10
      else $error("setting changed while request high");
   AST_SUPPRESS: assert property (CE && DIAG_EVT && sup.active |=> !DIAG_STORE && !$rose(DIAG_DETECTED)) // see RL9
      else $error("diagnostic notified inside window");
   AST_OWN_RANGE: assert property (own_q <= 16'h007D || own_q == OWN_NONE) // see RL14
      else $error("own address out of range");
   AST_MIN_LE_CUR: assert property (CE && CYCLE_END |=> min_q <= cur_q) // see RL16
      else $error("minimum above latest cycle time");
   AST_READ_WAIT: assert property (CE && addr_ok && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
      else $error("read wait state missing");
   CV_GC_BOTH: cover property (GC_REQ && GC_UNSYNC && cmd_q[CMD_SYNC]);
   CV_DIAG_DROP: cover property (CE && DIAG_EVT && sup.active);
   CV_DIAG_PASS: cover property (DIAG_STORE);
   CV_CYCLE: cover property (CE && CYCLE_END && ms_now != 16'h0000);
endmodule : dpmgc_top
`default_nettype wire
